//--- logic/sdc_pkg.sv
// Purpose: Constants for the SPI control register bank of a stepper driver.
// Assumes: 16-bit SPI frames, address byte first, MSB first.
// Notes:   Register offsets are 5-bit effective addresses after bank select.
package sdc_pkg;

   localparam logic [4:0] SDC_STEP_DIRECTION_CONFIG   = 5'h01;
   localparam logic [4:0] SDC_COIL_CURRENT_LEVELS     = 5'h02;
   localparam logic [4:0] SDC_DRIVE_MODE_CONFIG       = 5'h03;
   localparam logic [4:0] SDC_STALL_TIMEOUT           = 5'h04;
   localparam logic [4:0] SDC_SPEED_THRESHOLD         = 5'h05;
   localparam logic [4:0] SDC_UNDERVOLTAGE_THRESHOLDS = 5'h06;
   localparam logic [4:0] SDC_BANK_AND_INT_ENABLES    = 5'h07;
   localparam logic [4:0] SDC_OPEN_COIL_BOOST_CONFIG  = 5'h14;

   localparam logic [7:0] SDC_RST_STEP_DIR   = 8'h00;
   localparam logic [7:0] SDC_RST_CURRENT    = 8'h00;
   localparam logic [7:0] SDC_RST_DRIVE_MODE = 8'h20;
   localparam logic [7:0] SDC_RST_STALL_TO   = 8'h10;
   localparam logic [7:0] SDC_RST_SPEED      = 8'h00;
   localparam logic [7:0] SDC_RST_UNDERVOLT  = 8'h00;
   localparam logic [7:0] SDC_RST_BANK_INT   = 8'h00;
   localparam logic [7:0] SDC_RST_OPEN_COIL  = 8'h04;

   localparam logic [7:0] SDC_OPEN_COIL_MASK = 8'h1f;

   localparam int SDC_BIT_DIR_INV    = 7;
   localparam int SDC_BIT_RHB_INV    = 6;
   localparam int SDC_BIT_NEXT_STEP  = 5;
   localparam int SDC_BIT_BRIDGE_ON  = 4;
   localparam int SDC_BIT_ENH_BEMF   = 7;
   localparam int SDC_BIT_AUTO_DIAG  = 6;
   localparam int SDC_BIT_SLEEP      = 3;
   localparam int SDC_BIT_BANK_SEL   = 7;

   localparam logic [3:0] SDC_NOP_ADDR   = 4'h0;
   localparam logic [4:0] SDC_FRAME_BITS = 5'd16;
   localparam logic [3:0] SDC_BIT_MASK   = 4'hf;

endpackage : sdc_pkg

//--- logic/sdc_regbank.sv
// Purpose: SPI slave and control register bank of a micro-stepping driver.
// Assumes: spi_clk idles low; frames are whole multiples of 16 bits.
// Notes:   Shift logic runs on spi_clk; registers live in the mclk domain.
module sdc_regbank
   import sdc_pkg::*;
(
   input  wire logic       mclk,                 // System clock, 40 MHz.
   input  wire logic       reset_n,              // Asynchronous reset, active low.
   input  wire logic       spi_clk,              // SPI serial clock from master.
   input  wire logic       chip_select_n,        // SPI select, active low.
   input  wire logic       spi_din,              // SPI data from master.
   output logic            spi_dout,             // SPI data to master.
   output logic            spi_dout_oe,          // High while driving spi_dout.
   input  wire logic       direction_pin,        // Direction pin.
   input  wire logic       run_hold_pin,         // Run/hold pin.
   input  wire logic       next_step_pin,        // Hardware next-step pin.
   input  wire logic [7:0] speed_value,          // Measured speed.
   input  wire logic [7:0] status_data,          // Status register read data.
   output logic [3:0]      status_addr,          // Status register being read.
   output logic            step_direction,       // Effective step direction.
   output logic            hold_state,           // One in hold, zero in run.
   output logic            step_advance,         // One-cycle micro-step pulse.
   output logic            bridge_enable,        // Both H-bridges enabled.
   output logic            stall_detect_on,      // Stall detection active.
   output logic            backemf_on,           // Back-EMF measurement active.
   output logic            enhanced_backemf_on,  // Enhanced back-EMF enable.
   output logic            diag_start,           // One-cycle diagnostic start.
   output logic [3:0]      stall_level,          // Stall threshold.
   output logic [3:0]      coil_current,         // Current amplitude in use.
   output logic [1:0]      slew_select,          // Switching slope.
   output logic            sleep_request,        // Sleep state request.
   output logic [2:0]      microstep_select,     // Step mode.
   output logic [7:0]      stall_timeout_value,  // Stall timeout setting.
   output logic [3:0]      undervolt_level_one,  // First UV threshold.
   output logic [3:0]      undervolt_level_two,  // Second UV threshold.
   output logic [6:0]      int_enables,          // Gain and interrupt enables.
   output logic [4:0]      open_coil_config,     // Open-coil and boost setting.
   output logic            spi_error             // Framing error flag.
);

   // ----------------------------------------------------------------
   // Link domain: shift in, shift out.
   // ----------------------------------------------------------------
   logic [4:0]  bit_cnt;
   logic [14:0] rx_shift;
   logic [15:0] rx_word;
   logic        rx_toggle;
   logic        frame_bad;
   logic [15:0] tx_word;
   logic [3:0]  fall_cnt;
   logic [7:0]  tx_byte1;
   logic [7:0]  tx_byte2;

   always_ff @(posedge spi_clk or posedge chip_select_n or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt <= 5'd0;
      end else if (chip_select_n) begin
         bit_cnt <= 5'd0;
      end else begin
         bit_cnt <= (bit_cnt == SDC_FRAME_BITS - 5'd1) ? 5'd0 : bit_cnt + 5'd1;
      end
   end

   always_ff @(posedge spi_clk) begin
      rx_shift <= {rx_shift[13:0], spi_din};
   end

   // A whole word is handed over by toggle; the word stays stable a full frame.
   always_ff @(posedge spi_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_word   <= 16'h0000;
         rx_toggle <= 1'b0;
      end else if (!chip_select_n && bit_cnt == SDC_FRAME_BITS - 5'd1) begin
         rx_word   <= {rx_shift, spi_din};
         rx_toggle <= ~rx_toggle;
      end
   end

   // The verdict of the last clock edge is kept after select rises, so the
   // mclk side still reads it when it sees the frame end. Clearing it on the
   // select edge would hide every bad frame from the slower domain.
   // count check
   always_ff @(posedge spi_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_bad <= 1'b0;
      end else if (!chip_select_n) begin
         frame_bad <= (bit_cnt != SDC_FRAME_BITS - 5'd1);
      end
   end

   // The reply word is only indexed here: it is written in the mclk domain a
   // few cycles after a frame ends and then stays put until the next frame
   // has ended, so it needs no handshake while it is shifted out.
   // shift on falling
   always_ff @(negedge spi_clk or posedge chip_select_n or negedge reset_n) begin
      if (!reset_n) begin
         fall_cnt <= 4'h0;
      end else if (chip_select_n) begin
         fall_cnt <= 4'h0;
      end else begin
         fall_cnt <= fall_cnt + 4'h1;
      end
   end

   always_comb begin
      spi_dout    = tx_word[~fall_cnt];
      spi_dout_oe = !chip_select_n;
   end

   // ----------------------------------------------------------------
   // Crossings into mclk.
   // ----------------------------------------------------------------
   logic [2:0] tog_sync;
   logic [2:0] cs_sync;
   logic [1:0] pin_dir_sync;
   logic [1:0] pin_rhb_sync;
   logic [2:0] pin_nxt_sync;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tog_sync     <= 3'b000;
         cs_sync      <= 3'b111;
         pin_dir_sync <= 2'b00;
         pin_rhb_sync <= 2'b00;
         pin_nxt_sync <= 3'b000;
      end else begin
         tog_sync     <= {tog_sync[1:0], rx_toggle};
         cs_sync      <= {cs_sync[1:0], chip_select_n};
         pin_dir_sync <= {pin_dir_sync[0], direction_pin};
         pin_rhb_sync <= {pin_rhb_sync[0], run_hold_pin};
         pin_nxt_sync <= {pin_nxt_sync[1:0], next_step_pin};
      end
   end

   logic word_ready;
   logic frame_end;
   assign word_ready = tog_sync[2] ^ tog_sync[1];
   assign frame_end  = cs_sync[1] & ~cs_sync[2];

   // ----------------------------------------------------------------
   // Register bank.
   // ----------------------------------------------------------------
   logic [7:0] step_direction_config;
   logic [7:0] coil_current_levels;
   logic [7:0] drive_mode_config;
   logic [7:0] stall_timeout;
   logic [7:0] speed_threshold;
   logic [7:0] undervoltage_thresholds;
   logic [7:0] bank_and_interrupt_enables;
   logic [7:0] open_coil_boost_config;
   logic [15:0] pend_word;
   logic        pend_valid;
   logic [4:0]  wr_addr;
   logic [4:0]  rd_addr;
   logic        bank_bit;

   assign bank_bit = bank_and_interrupt_enables[SDC_BIT_BANK_SEL];
   assign wr_addr  = {bank_bit, pend_word[15:12]};
   assign rd_addr  = {bank_bit, pend_word[11:8]};

   // Completed words wait for the frame end so a bad count can still cancel them.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pend_word  <= 16'h0000;
         pend_valid <= 1'b0;
      end else if (frame_end) begin
         pend_valid <= 1'b0;
      end else if (word_ready) begin
         pend_word  <= rx_word;
         pend_valid <= 1'b1;
      end
   end

   logic [1:0] bad_sync;
   logic       frame_bad_sync;
   logic       commit;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bad_sync <= 2'b00;
      end else begin
         bad_sync <= {bad_sync[0], frame_bad};
      end
   end
   // The flag last moved a clock period before select rose, so its
   // synchronised copy has settled by the time the frame end is seen.
   assign frame_bad_sync = bad_sync[1];

   assign commit = frame_end & pend_valid & ~frame_bad_sync;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         step_direction_config      <= SDC_RST_STEP_DIR;
         coil_current_levels        <= SDC_RST_CURRENT;
         drive_mode_config          <= SDC_RST_DRIVE_MODE;
         stall_timeout              <= SDC_RST_STALL_TO;
         speed_threshold            <= SDC_RST_SPEED;
         undervoltage_thresholds    <= SDC_RST_UNDERVOLT;
         bank_and_interrupt_enables <= SDC_RST_BANK_INT;
         open_coil_boost_config     <= SDC_RST_OPEN_COIL;
      end else if (commit) begin
         unique case (wr_addr)
            SDC_STEP_DIRECTION_CONFIG:   step_direction_config      <= pend_word[7:0];
            SDC_COIL_CURRENT_LEVELS,
            5'h12:                       coil_current_levels        <= pend_word[7:0];
            SDC_DRIVE_MODE_CONFIG,
            5'h13:                       drive_mode_config          <= pend_word[7:0];
            SDC_STALL_TIMEOUT:           stall_timeout              <= pend_word[7:0];
            SDC_SPEED_THRESHOLD,
            5'h15:                       speed_threshold            <= pend_word[7:0];
            SDC_UNDERVOLTAGE_THRESHOLDS,
            5'h16:                       undervoltage_thresholds    <= pend_word[7:0];
            SDC_BANK_AND_INT_ENABLES,
            5'h17:                       bank_and_interrupt_enables <= pend_word[7:0];
            SDC_OPEN_COIL_BOOST_CONFIG:
               open_coil_boost_config <= pend_word[7:0] & SDC_OPEN_COIL_MASK;
            5'h11:                       step_direction_config      <= pend_word[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; status slots are passed to the status logic outside.
   function automatic logic [7:0] sdc_read(input logic [4:0] a,
                                           input logic [7:0] st);
      logic [7:0] v;
      v = 8'h00;
      if (a[3:0] == SDC_NOP_ADDR) begin
         v = 8'h00;
      end else if (a[3]) begin
         v = st;
      end else begin
         unique case (a)
            5'h01, 5'h11: v = step_direction_config;
            5'h02, 5'h12: v = coil_current_levels;
            5'h03, 5'h13: v = drive_mode_config;
            5'h04:        v = stall_timeout;
            5'h14:        v = open_coil_boost_config;
            5'h05, 5'h15: v = speed_threshold;
            5'h06, 5'h16: v = undervoltage_thresholds;
            5'h07, 5'h17: v = bank_and_interrupt_enables;
            default:      v = 8'h00;
         endcase
      end
      return v;
   endfunction : sdc_read

   // Status reads are served by outside logic one address at a time, so the
   // two slots are captured on the two cycles after the commit. The slot
   // addresses are frozen at the commit, so a bank change made by the same
   // frame cannot move the read-back, and a written register answers with
   // the value it now holds.
   logic [1:0] cap_phase;
   logic [4:0] wr_slot;
   logic [4:0] rd_slot;
   assign status_addr = cap_phase[1] ? rd_slot[3:0] : wr_slot[3:0];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_byte1  <= 8'h00;
         tx_byte2  <= 8'h00;
         wr_slot   <= 5'h00;
         rd_slot   <= 5'h00;
         cap_phase <= 2'b00;
      end else if (commit) begin
         wr_slot   <= wr_addr;
         rd_slot   <= rd_addr;
         cap_phase <= 2'b01;
      end else if (cap_phase[0]) begin
         tx_byte1  <= sdc_read(wr_slot, status_data);
         cap_phase <= 2'b10;
      end else if (cap_phase[1]) begin
         tx_byte2  <= sdc_read(rd_slot, status_data);
         cap_phase <= 2'b00;
      end
   end
   assign tx_word = {tx_byte1, tx_byte2};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         spi_error <= 1'b0;
      end else if (frame_end && frame_bad_sync) begin
         spi_error <= 1'b1;
      end else if (commit && wr_addr[3:0] == 4'h8) begin
         spi_error <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control outputs.
   // ----------------------------------------------------------------
   logic bridge_d;
   logic nxt_soft_d;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bridge_d     <= 1'b0;
         nxt_soft_d   <= 1'b0;
         diag_start   <= 1'b0;
         step_advance <= 1'b0;
      end else begin
         bridge_d     <= step_direction_config[SDC_BIT_BRIDGE_ON];
         nxt_soft_d   <= step_direction_config[SDC_BIT_NEXT_STEP];
         diag_start   <= drive_mode_config[SDC_BIT_AUTO_DIAG]
                         & step_direction_config[SDC_BIT_BRIDGE_ON] & ~bridge_d;
         step_advance <= (step_direction_config[SDC_BIT_NEXT_STEP] & ~nxt_soft_d)
                         | (pin_nxt_sync[1] & ~pin_nxt_sync[2]);
      end
   end

   always_comb begin
      step_direction      = pin_dir_sync[1] ^ step_direction_config[SDC_BIT_DIR_INV];
      hold_state          = ~(pin_rhb_sync[1] ^ step_direction_config[SDC_BIT_RHB_INV]);
      bridge_enable       = step_direction_config[SDC_BIT_BRIDGE_ON];
      stall_level         = step_direction_config[3:0];
      coil_current        = hold_state ? coil_current_levels[7:4] : coil_current_levels[3:0];
      backemf_on          = (speed_value <= speed_threshold);
      stall_detect_on     = backemf_on && (stall_level != 4'h0);
      enhanced_backemf_on = drive_mode_config[SDC_BIT_ENH_BEMF];
      slew_select         = drive_mode_config[5:4];
      sleep_request       = drive_mode_config[SDC_BIT_SLEEP];
      microstep_select    = drive_mode_config[2:0];
      stall_timeout_value = stall_timeout;
      undervolt_level_one = undervoltage_thresholds[7:4];
      undervolt_level_two = undervoltage_thresholds[3:0];
      int_enables         = bank_and_interrupt_enables[6:0];
      open_coil_config    = open_coil_boost_config[4:0];
   end

endmodule : sdc_regbank

//--- test/sdc_regbank_props.sv
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: Frames are spaced by at least 8 mclk cycles.
// Notes:   Bound to every sdc_regbank instance below.
module sdc_regbank_props (
   input wire logic       mclk,                // System clock.
   input wire logic       reset_n,             // Reset, active low.
   input wire logic       chip_select_n,       // SPI select.
   input wire logic       spi_dout_oe,         // Output drive enable.
   input wire logic       step_advance,        // Step pulse.
   input wire logic       bridge_enable,       // Bridge enable.
   input wire logic       stall_detect_on,     // Stall detection.
   input wire logic       backemf_on,          // Back-EMF active.
   input wire logic       diag_start,          // Diagnostic pulse.
   input wire logic [3:0] stall_level,         // Stall threshold.
   input wire logic [7:0] stall_timeout_value, // Stall timeout.
   input wire logic [4:0] open_coil_config,    // Open-coil setting.
   input wire logic       spi_error            // Framing error.
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // Six cycles into a frame the previous commit is long done, so any
   // change seen here would be a stray write.
   sequence s_in_frame;
      !chip_select_n [*6];
   endsequence

   a_dout_enable: assert property (spi_dout_oe == !chip_select_n)
      else $error("data output enable does not follow select");
   a_regs_steady: assert property (s_in_frame |-> $stable(stall_level) &&
      $stable(stall_timeout_value) && $stable(open_coil_config) && $stable(bridge_enable))
      else $error("register output changed inside a frame");
   a_error_outside: assert property ($changed(spi_error) |-> chip_select_n
      && $past(chip_select_n)) else $error("framing error changed inside a frame");
   a_stall_zero: assert property (stall_level == 4'h0 |-> !stall_detect_on)
      else $error("stall detection active with zero threshold");
   a_stall_speed: assert property (!backemf_on |-> !stall_detect_on)
      else $error("stall detection active above speed limit");
   a_step_pulse: assert property (step_advance |=> !step_advance)
      else $error("step pulse longer than one cycle");
   a_diag_pulse: assert property (diag_start |=> !diag_start)
      else $error("diagnostic start longer than one cycle");
   a_diag_bridge: assert property (diag_start |-> bridge_enable)
      else $error("diagnostic start without bridge enable");
endmodule : sdc_regbank_props

bind sdc_regbank sdc_regbank_props i_sdc_regbank_props (.mclk, .reset_n, .chip_select_n,
   .spi_dout_oe, .step_advance, .bridge_enable, .stall_detect_on, .backemf_on, .diag_start,
   .stall_level, .stall_timeout_value, .open_coil_config, .spi_error);

//--- test/sdc_spi_master.sv
// Purpose: SPI master model standing in for the microcontroller.
// Assumes: Link clock of 64 ns, idle low, running only inside frames.
// Notes:   Between frames the data line shows the inverse of its last bit.
module sdc_spi_master (
   output logic      spi_clk,       // Link clock.
   output logic      chip_select_n, // Select, active low.
   output logic      spi_din,       // Data to the device.
   input  wire logic spi_dout,      // Data from the device.
   input  wire logic spi_dout_oe    // High while the device drives.
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      spi_din = 1'b1;
   end

   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
      r = 16'h0000;
      chip_select_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi_din = w[15 - i];
         #32 spi_clk = 1'b1;
         r = {r[14:0], spi_dout_oe ? spi_dout : 1'bx};
         #32 spi_clk = 1'b0;
      end
      #32 chip_select_n = 1'b1;
      spi_din = ~spi_din;
      #400;
   endtask : xfer
endmodule : sdc_spi_master

//--- test/test_sdc_regbank.sv
// Purpose: Self-checking bench for the SPI control register bank.
// Assumes: Replies appear one frame after their request.
// Notes:   Status slots answer 0xA in the upper nibble, the slot below.
module test_sdc_regbank
   import sdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk = 1'b0, reset_n = 1'b1, spi_clk, chip_select_n, spi_din;
   logic        spi_dout, spi_dout_oe, step_direction, hold_state, step_advance;
   logic        direction_pin = 1'b0, run_hold_pin = 1'b0, next_step_pin = 1'b0;
   logic        bridge_enable, stall_detect_on, backemf_on, enhanced_backemf_on;
   logic        diag_start, sleep_request, spi_error;
   logic [1:0]  slew_select;
   logic [2:0]  microstep_select;
   logic [3:0]  status_addr, stall_level, coil_current, undervolt_level_one, undervolt_level_two;
   logic [4:0]  open_coil_config;
   logic [6:0]  int_enables;
   logic [7:0]  speed_value = 8'h00, status_data, stall_timeout_value, v;
   logic [15:0] rep;
   int          error_cnt = 0, checks_done = 0, step_cnt = 0, diag_cnt = 0;

   always #12.5 mclk = ~mclk;
   assign status_data = {4'ha, status_addr};
   always @(posedge mclk) begin
      if (step_advance === 1'b1)
         step_cnt <= step_cnt + 1;
      if (diag_start === 1'b1)
         diag_cnt <= diag_cnt + 1;
   end

   sdc_spi_master i_sdc_spi_master (.spi_clk, .chip_select_n, .spi_din, .spi_dout, .spi_dout_oe);
   sdc_regbank i_sdc_regbank (.mclk, .reset_n, .spi_clk, .chip_select_n, .spi_din, .spi_dout,
      .spi_dout_oe, .direction_pin, .run_hold_pin, .next_step_pin, .speed_value, .status_data,
      .status_addr, .step_direction, .hold_state, .step_advance, .bridge_enable,
      .stall_detect_on, .backemf_on, .enhanced_backemf_on, .diag_start, .stall_level,
      .coil_current, .slew_select, .sleep_request, .microstep_select, .stall_timeout_value,
      .undervolt_level_one, .undervolt_level_two, .int_enables, .open_coil_config, .spi_error);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic send(input logic [15:0] w);
      i_sdc_spi_master.xfer(w, 16, rep);
   endtask : send

   // Read frames carry a data byte of ones, which must not land anywhere.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      send({4'h0, a, 8'hff});
      send(16'h0000);
      check(rep[15:8], 8'h00);
      d = rep[7:0];
   endtask : rd

   task automatic t_reset;
      logic [7:0] rv [1:7] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00};
      send(16'h0000);
      for (int k = 1; k < 8; k++) begin
         rd(4'(k), v);
         check(v, rv[k]);
      end
   endtask : t_reset

   task automatic t_write;
      logic [7:0] d;
      for (int k = 1; k < 7; k++) begin
         d = {4'(k), ~4'(k)};
         send({4'(k), 4'h0, d});
         send(16'h0000);
         check(rep, {d, 8'h00});
         rd(4'(k), v);
         check(v, d);
      end
      check({bridge_enable, stall_level}, 5'h1e);
      check({slew_select, sleep_request, microstep_select}, 6'h3c);
      check(stall_timeout_value, 8'h4b);
      check({undervolt_level_one, undervolt_level_two}, 8'h69);
      check(16'(diag_cnt), 16'h0000);
   endtask : t_write

   task automatic t_bank;
      send(16'h70bf);
      check(int_enables, 7'h3f);
      rd(4'h4, v);
      check(v, SDC_RST_OPEN_COIL);
      send(16'h40ff);
      rd(4'h4, v);
      check({v, 3'h0, open_coil_config}, 16'h1f1f);
      check(stall_timeout_value, 8'h4b);
      send(16'h7000);
      rd(4'h4, v);
      check(v, 8'h4b);
   endtask : t_bank

   task automatic t_error;
      send(16'h0200);
      i_sdc_spi_master.xfer(16'h5077, 15, rep);
      check(spi_error, 1'b1);
      send(16'h0000);
      check(rep, 16'h002d);
      rd(4'h5, v);
      check(v, 8'h5a);
      send(16'h8000);
      check(spi_error, 1'b0);
      send(16'h0000);
      check(rep, 16'ha800);
   endtask : t_error

   task automatic t_pins;
      logic inv, dp, rp;
      for (int n = 0; n < 8; n++) begin
         {inv, dp, rp} = 3'(n);
         send({4'h1, 4'h0, inv, inv, 6'h1e});
         @(negedge mclk);
         direction_pin = dp;
         run_hold_pin = rp;
         repeat (4) @(negedge mclk);
         check(step_direction, dp ^ inv);
         check(hold_state, !(rp ^ inv));
         check(coil_current, (rp ^ inv) ? 4'hd : 4'h2);
      end
   endtask : t_pins

   task automatic t_step;
      send(16'h103e);
      @(negedge mclk);
      next_step_pin = 1'b1;
      repeat (6) @(negedge mclk);
      check(16'(step_cnt), 16'h0002);
   endtask : t_step

   task automatic t_diag;
      send(16'h30e0);
      check({enhanced_backemf_on, slew_select}, 3'h6);
      check(sleep_request, 1'b0);
      send(16'h1003);
      check(bridge_enable, 1'b0);
      send(16'h1013);
      check(16'(diag_cnt), 16'h0001);
      send(16'h5040);
      for (int s = 1; s >= 0; s--) begin
         @(negedge mclk);
         speed_value = 8'h40 + 8'(s);
         repeat (2) @(negedge mclk);
         check({backemf_on, stall_detect_on}, s ? 2'b00 : 2'b11);
      end
      send(16'h1010);
      check({backemf_on, stall_detect_on}, 2'b10);
   endtask : t_diag

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Reset is asserted after time zero so that the link-side flops, which
   // only react to the reset edge, start from known values.
   initial begin
      @(negedge mclk);
      reset_n = 1'b0;
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset;
      t_write;
      t_bank;
      t_error;
      t_pins;
      t_step;
      t_diag;
      complete_run;
   end

   // The run needs about 100 us; four times that means a hang.
   initial begin
      #400us;
      error_cnt++;
      complete_run;
   end
endmodule : test_sdc_regbank
